// >>> jlink_pkg.sv
package jlink_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] LINK_IDENTIFIER_OFFSET = 12'h206;
	localparam logic [11:0] FRAME_END_CHARACTER_SELECT_OFFSET = 12'h207;
	localparam logic [11:0] LINK_AND_PLL_STATUS_OFFSET = 12'h208;
	localparam logic [7:0] LINK_IDENTIFIER_RESET = 8'h00;
	localparam logic [7:0] FRAME_END_CHARACTER_SELECT_RESET = 8'h00;
	localparam logic [7:0] LINK_AND_PLL_STATUS_RESET = 8'h00;
	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int STAT_LINK_UP_BIT = 6;
	localparam int STAT_SYNC_BIT = 5;
	localparam int STAT_REALIGNED_BIT = 4;
	localparam int STAT_MF_PHASE_BIT = 3;
	localparam int STAT_SER_PLL_BIT = 2;
	localparam int STAT_CONV_PLL_BIT = 0;
	localparam logic [7:0] STATUS_W1C_MASK = 8'h18;
	// ****************************************
	// Comma selections and 8B/10B control codes
	// ****************************************
	localparam logic [1:0] COMMA_SEL_K28_7 = 2'h0;
	localparam logic [1:0] COMMA_SEL_K28_1 = 2'h1;
	localparam logic [1:0] COMMA_SEL_K28_5 = 2'h2;
	localparam logic [7:0] K28_7_CODE = 8'hFC;
	localparam logic [7:0] K28_1_CODE = 8'h3C;
	localparam logic [7:0] K28_5_CODE = 8'hBC;
	// ****************************************
	// Controller registers
	// ****************************************
	localparam logic [3:0] CTL_ADDR_OFFSET = 4'h0;
	localparam logic [3:0] CTL_WDATA_OFFSET = 4'h1;
	localparam logic [3:0] CTL_CMD_OFFSET = 4'h2;
	localparam logic [3:0] CTL_RDATA_OFFSET = 4'h3;
	localparam logic [3:0] CTL_IRQ_STATUS_OFFSET = 4'h4;
	localparam logic [3:0] CTL_IRQ_MASK_OFFSET = 4'h5;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_REFUSED_BIT = 1;
	localparam logic [7:0] CTL_RESET = 8'h00;

	function automatic logic [7:0] comma_code(input logic [1:0] sel);
		unique case (sel)
			COMMA_SEL_K28_1: comma_code = K28_1_CODE;
			COMMA_SEL_K28_5: comma_code = K28_5_CODE;
			default: comma_code = K28_7_CODE;
		endcase
	endfunction
endpackage

// >>> jlink_if.sv
`timescale 1ns/1ns
interface jlink_if;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport device (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> jlink_regs.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - Link identifier goes into second ILA multiframe
// - Change selections only while link disabled
// - Comma select: 0 K28.7, 1 K28.1, 2 K28.5
// - Comma sent opportunistically, 8B/10B modes only
// - Keep default comma for standard receivers
// - Bit 6 shows link up
// - Bit 5 shows live sync request state
// - Bit 4 set on realignment, write-one clears
// - Bit 3 set by first SYSREF after enable
// - Bit 2 shows serializer PLL lock
// - Bit 0 shows converter PLL lock
// - Software writes zero into reserved select bits
module jlink_regs
	import jlink_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	jlink_if.device bus,
	input wire logic link_enable_control_i,
	input wire logic link_up_i,
	input wire logic sync_n_i,
	input wire logic sysref_realign_i,
	input wire logic sysref_event_i,
	input wire logic serializer_pll_lock_flag_i,
	input wire logic converter_pll_lock_flag_i,
	input wire logic ila_mf2_i,
	input wire logic frame_end_slot_i,
	input wire logic mode_8b10b_i,
	output logic [7:0] link_identifier_field_o,
	output logic [7:0] ila_mf2_byte_o,
	output logic [7:0] frame_end_char_o,
	output logic frame_end_is_k_o
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [6:0] sync1_reg, sync2_reg;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end else if (ce_i) begin
			sync1_reg <= {link_up_i, sync_n_i, sysref_realign_i, sysref_event_i,
				serializer_pll_lock_flag_i, converter_pll_lock_flag_i, link_enable_control_i};
			sync2_reg <= sync1_reg;
		end
	end
	logic s_link_up, s_sync_n, s_realign, s_sysref, s_spll, s_cpll, s_en;
	assign {s_link_up, s_sync_n, s_realign, s_sysref, s_spll, s_cpll, s_en} = sync2_reg;

	// ****************************************
	// Configuration fields
	// ****************************************
	logic [7:0] link_identifier_field_reg, link_identifier_field_next;
	logic [1:0] frame_end_comma_select_reg, frame_end_comma_select_next;
	logic wr_id, wr_sel, wr_stat;

	always_comb begin
		wr_id = bus.wr && (bus.addr == LINK_IDENTIFIER_OFFSET);
		wr_sel = bus.wr && (bus.addr == FRAME_END_CHARACTER_SELECT_OFFSET);
		wr_stat = bus.wr && (bus.addr == LINK_AND_PLL_STATUS_OFFSET);
		link_identifier_field_next = link_identifier_field_reg;
		frame_end_comma_select_next = frame_end_comma_select_reg;
		if (wr_id) begin
			link_identifier_field_next = bus.wdata;
		end
		if (wr_sel) begin
			frame_end_comma_select_next = bus.wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			link_identifier_field_reg <= LINK_IDENTIFIER_RESET;
			frame_end_comma_select_reg <= FRAME_END_CHARACTER_SELECT_RESET[1:0];
		end else if (ce_i) begin
			link_identifier_field_reg <= link_identifier_field_next;
			frame_end_comma_select_reg <= frame_end_comma_select_next;
		end
	end

	// ****************************************
	// Sticky SYSREF flags
	// ****************************************
	logic realigned_reg, realigned_next;
	logic multiframe_phase_set_flag_reg, multiframe_phase_set_flag_next;
	logic armed_reg, armed_next;
	logic sysref_d_reg, sysref_d_next;
	logic realign_d_reg, realign_d_next;
	logic sysref_rise, realign_rise;

	always_comb begin
		sysref_d_next = s_sysref;
		realign_d_next = s_realign;
		sysref_rise = s_sysref && !sysref_d_reg;
		realign_rise = s_realign && !realign_d_reg;
		// Set wins over a same-cycle clear; zero writes leave bits alone
		realigned_next = realigned_reg;
		if (wr_stat && bus.wdata[STAT_REALIGNED_BIT]) begin
			realigned_next = 1'b0;
		end
		if (realign_rise) begin
			realigned_next = 1'b1;
		end
		// Rearmed while disabled, spent by the first SYSREF after enable
		armed_next = s_en ? armed_reg : 1'b1;
		multiframe_phase_set_flag_next = multiframe_phase_set_flag_reg;
		if (wr_stat && bus.wdata[STAT_MF_PHASE_BIT]) begin
			multiframe_phase_set_flag_next = 1'b0;
		end
		if (s_en && armed_reg && sysref_rise) begin
			multiframe_phase_set_flag_next = 1'b1;
			armed_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			realigned_reg <= 1'b0;
			multiframe_phase_set_flag_reg <= 1'b0;
			armed_reg <= 1'b1;
			sysref_d_reg <= 1'b0;
			realign_d_reg <= 1'b0;
		end else if (ce_i) begin
			realigned_reg <= realigned_next;
			multiframe_phase_set_flag_reg <= multiframe_phase_set_flag_next;
			armed_reg <= armed_next;
			sysref_d_reg <= sysref_d_next;
			realign_d_reg <= realign_d_next;
		end
	end

	// ****************************************
	// Status and read port
	// ****************************************
	logic [7:0] status_now;
	logic [7:0] rdata_reg, rdata_next;

	always_comb begin
		status_now = LINK_AND_PLL_STATUS_RESET;
		status_now[STAT_LINK_UP_BIT] = s_link_up;
		status_now[STAT_SYNC_BIT] = s_sync_n;
		status_now[STAT_REALIGNED_BIT] = realigned_reg;
		status_now[STAT_MF_PHASE_BIT] = multiframe_phase_set_flag_reg;
		status_now[STAT_SER_PLL_BIT] = s_spll;
		status_now[STAT_CONV_PLL_BIT] = s_cpll;
	end

	always_comb begin
		rdata_next = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				LINK_IDENTIFIER_OFFSET: rdata_next = link_identifier_field_reg;
				FRAME_END_CHARACTER_SELECT_OFFSET: rdata_next = {6'h00, frame_end_comma_select_reg};
				LINK_AND_PLL_STATUS_OFFSET: rdata_next = status_now;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (ce_i) begin
			rdata_reg <= rdata_next;
		end
	end

	assign bus.rdata = rdata_reg;

	// ****************************************
	// Link side outputs
	// ****************************************
	logic [7:0] ila_reg, ila_next;
	logic [7:0] fe_char_reg, fe_char_next;
	logic fe_k_reg, fe_k_next;

	always_comb begin
		ila_next = ila_mf2_i ? link_identifier_field_reg : 8'h00;
		fe_k_next = frame_end_slot_i && mode_8b10b_i;
		fe_char_next = fe_k_next ? comma_code(frame_end_comma_select_reg) : 8'h00;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ila_reg <= 8'h00;
			fe_char_reg <= 8'h00;
			fe_k_reg <= 1'b0;
		end else if (ce_i) begin
			ila_reg <= ila_next;
			fe_char_reg <= fe_char_next;
			fe_k_reg <= fe_k_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link_identifier_field_o = link_identifier_field_reg;
	assign ila_mf2_byte_o = ila_reg;
	assign frame_end_char_o = fe_char_reg;
	assign frame_end_is_k_o = fe_k_reg;
endmodule

// >>> jlink_ctrl.sv
`timescale 1ns/1ns
module jlink_ctrl
	import jlink_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	jlink_if.host bus,
	input wire logic link_enable_control_i,
	input wire logic [3:0] sw_addr_i,
	input wire logic [7:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [7:0] sw_rdata_o,
	output logic irq_o
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CAPT = 3'b100
	} state_type;

	// ****************************************
	// Controller state
	// ****************************************
	state_type state_reg, state_next;
	logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next, cap_reg, cap_next;
	logic [1:0] irq_st_reg, irq_st_next, irq_mask_reg, irq_mask_next;
	logic [7:0] sw_rdata_reg, sw_rdata_next;
	logic irq_reg, irq_next;
	logic [11:0] b_addr_reg, b_addr_next;
	logic [7:0] b_wdata_reg, b_wdata_next;
	logic b_wr_reg, b_wr_next, b_rd_reg, b_rd_next;
	logic go_wr, go_rd, refused, done;
	logic [11:0] tgt;

	always_comb begin
		go_wr = sw_wr_i && sw_addr_i == CTL_CMD_OFFSET && sw_wdata_i[CMD_WRITE_BIT];
		go_rd = sw_wr_i && sw_addr_i == CTL_CMD_OFFSET && sw_wdata_i[CMD_READ_BIT];
		tgt = {4'h2, addr_reg};
		addr_next = (sw_wr_i && sw_addr_i == CTL_ADDR_OFFSET) ? sw_wdata_i : addr_reg;
		wdata_next = (sw_wr_i && sw_addr_i == CTL_WDATA_OFFSET) ? sw_wdata_i : wdata_reg;
		irq_mask_next = (sw_wr_i && sw_addr_i == CTL_IRQ_MASK_OFFSET) ? sw_wdata_i[1:0]
			: irq_mask_reg;
		state_next = state_reg;
		cap_next = cap_reg;
		b_addr_next = b_addr_reg;
		b_wdata_next = b_wdata_reg;
		b_wr_next = 1'b0;
		b_rd_next = 1'b0;
		refused = 1'b0;
		done = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (go_wr) begin
					// Selections only change while the link is disabled
					if (link_enable_control_i && tgt != LINK_AND_PLL_STATUS_OFFSET) begin
						refused = 1'b1;
					end else begin
						b_addr_next = tgt;
						b_wdata_next = (tgt == FRAME_END_CHARACTER_SELECT_OFFSET)
							? {6'h00, wdata_reg[1:0]} : wdata_reg;
						b_wr_next = 1'b1;
						done = 1'b1;
					end
				end else if (go_rd) begin
					b_addr_next = tgt;
					b_rd_next = 1'b1;
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: state_next = ST_CAPT;
			ST_CAPT: begin
				cap_next = bus.rdata;
				done = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
		irq_st_next = irq_st_reg;
		sw_rdata_next = 8'h00;
		if (sw_rd_i) begin
			unique case (sw_addr_i)
				CTL_ADDR_OFFSET: sw_rdata_next = addr_reg;
				CTL_WDATA_OFFSET: sw_rdata_next = wdata_reg;
				CTL_CMD_OFFSET: sw_rdata_next = {7'h00, state_reg != ST_IDLE};
				CTL_RDATA_OFFSET: sw_rdata_next = cap_reg;
				CTL_IRQ_STATUS_OFFSET: begin
					sw_rdata_next = {6'h00, irq_st_reg};
					irq_st_next = 2'h0;
				end
				CTL_IRQ_MASK_OFFSET: sw_rdata_next = {6'h00, irq_mask_reg};
				default: sw_rdata_next = 8'h00;
			endcase
		end
		if (done)
			irq_st_next[IRQ_DONE_BIT] = 1'b1;
		if (refused)
			irq_st_next[IRQ_REFUSED_BIT] = 1'b1;
		irq_next = |(irq_st_next & irq_mask_next);
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			addr_reg <= CTL_RESET;
			wdata_reg <= CTL_RESET;
			cap_reg <= CTL_RESET;
			irq_st_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
			sw_rdata_reg <= 8'h00;
			irq_reg <= 1'b0;
			b_addr_reg <= 12'h000;
			b_wdata_reg <= 8'h00;
			b_wr_reg <= 1'b0;
			b_rd_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			cap_reg <= cap_next;
			irq_st_reg <= irq_st_next;
			irq_mask_reg <= irq_mask_next;
			sw_rdata_reg <= sw_rdata_next;
			irq_reg <= irq_next;
			b_addr_reg <= b_addr_next;
			b_wdata_reg <= b_wdata_next;
			b_wr_reg <= b_wr_next;
			b_rd_reg <= b_rd_next;
		end
	end

	assign bus.addr = b_addr_reg;
	assign bus.wdata = b_wdata_reg;
	assign bus.wr = b_wr_reg;
	assign bus.rd = b_rd_reg;
	assign sw_rdata_o = sw_rdata_reg;
	assign irq_o = irq_reg;
endmodule

// >>> jlink_sva.sv
`timescale 1ns/1ns
module jlink_sva
	import jlink_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic link_enable_control_i,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	// ****
	// Shadow of the writable fields
	// ****
	logic [7:0] id_reg;
	logic [1:0] sel_reg;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			id_reg <= 8'h00;
			sel_reg <= 2'h0;
		end else if (wr && addr == LINK_IDENTIFIER_OFFSET) begin
			id_reg <= wdata;
		end else if (wr && addr == FRAME_END_CHARACTER_SELECT_OFFSET) begin
			sel_reg <= wdata[1:0];
		end
	end
	sequence s_rd_id;
		rd && addr == LINK_IDENTIFIER_OFFSET;
	endsequence
	sequence s_rd_sel;
		rd && addr == FRAME_END_CHARACTER_SELECT_OFFSET;
	endsequence
	a_id_readback: assert property (s_rd_id |=> rdata == $past(id_reg))
		else $error("identifier read back wrong");
	a_sel_readback: assert property (s_rd_sel |=> rdata == {6'h00, $past(sel_reg)})
		else $error("comma select read back wrong");
	a_cfg_locked: assert property (wr && addr != LINK_AND_PLL_STATUS_OFFSET
		|-> !$past(link_enable_control_i)) else $error("config write while enabled");
	a_rsvd_wdata: assert property (wr && addr == FRAME_END_CHARACTER_SELECT_OFFSET
		|-> wdata[7:2] == 6'h00) else $error("reserved select bits written nonzero");
	a_status_rsvd: assert property (rd && addr == LINK_AND_PLL_STATUS_OFFSET
		|=> rdata[7] == 1'b0 && rdata[1] == 1'b0) else $error("reserved status bit set");
	a_unmapped_zero: assert property (rd && (addr < LINK_IDENTIFIER_OFFSET
		|| addr > LINK_AND_PLL_STATUS_OFFSET) |=> rdata == 8'h00) else $error("unmapped read");
	a_idle_rdata: assert property (!rd |=> rdata == 8'h00)
		else $error("read data without read");
	a_strobe_excl: assert property (wr |-> !rd) else $error("both strobes high");
endmodule

// >>> jesd_link_param_status_regs_tb.sv
`timescale 1ns/1ns
module jesd_link_param_status_regs_tb
	import jlink_pkg::*;
;
	logic clk_sys_i, rst_i, link_en, link_up, sync_n, realign, sref, spll, cpll;
	logic mf2, slot, m8, sw_wr, sw_rd, is_k, irq;
	logic [3:0] sw_addr;
	logic [7:0] sw_wdata, sw_rdata, id_o, mf2_o, fe_o, q, v;
	logic [7:0] ra[4] = '{8'h06, 8'h07, 8'h08, 8'hFF};
	logic [7:0] ctab[4] = '{K28_7_CODE, K28_1_CODE, K28_5_CODE, K28_7_CODE};
	int bad_count, checks_done, mdl_id, mdl_flags, mdl_mask;
	jlink_if bus_if();
	jlink_regs jlink_regs_i(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
		.bus(bus_if.device), .link_enable_control_i(link_en), .link_up_i(link_up),
		.sync_n_i(sync_n), .sysref_realign_i(realign), .sysref_event_i(sref),
		.serializer_pll_lock_flag_i(spll), .converter_pll_lock_flag_i(cpll),
		.ila_mf2_i(mf2), .frame_end_slot_i(slot), .mode_8b10b_i(m8),
		.link_identifier_field_o(id_o), .ila_mf2_byte_o(mf2_o),
		.frame_end_char_o(fe_o), .frame_end_is_k_o(is_k));
	jlink_ctrl jlink_ctrl_i(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
		.bus(bus_if.host), .link_enable_control_i(link_en), .sw_addr_i(sw_addr),
		.sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
		.sw_rdata_o(sw_rdata), .irq_o(irq));
	jlink_sva jlink_sva_i(.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.link_enable_control_i(link_en), .addr(bus_if.addr), .wdata(bus_if.wdata),
		.wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
	// ****
	// Bus tasks and checks
	// ****
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic sw(input logic [3:0] a, input logic [7:0] d, input bit r);
		@(posedge clk_sys_i);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= !r;
		sw_rd <= r;
		@(posedge clk_sys_i);
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
		#1 q = sw_rdata;
	endtask
	task automatic dev(input logic [7:0] a, input logic [7:0] d, input bit r,
		input logic [1:0] ei);
		sw(CTL_ADDR_OFFSET, a, 0);
		sw(CTL_WDATA_OFFSET, d, 0);
		sw(CTL_CMD_OFFSET, {6'h00, r, !r}, 0);
		repeat (4) @(posedge clk_sys_i);
		sw(CTL_RDATA_OFFSET, 8'h00, 1);
		v = q;
		chk(irq, |(ei & mdl_mask[1:0]));
		sw(CTL_IRQ_STATUS_OFFSET, 8'h00, 1);
		chk(q, {6'h00, ei});
		@(posedge clk_sys_i);
		#1 chk(irq, 1'b0);
	endtask
	function automatic logic [7:0] stat();
		return {1'b0, link_up, sync_n, mdl_flags[4:3], spll, 1'b0, cpll};
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		stop_test();
	end
	// ****
	// Scenarios
	// ****
	initial begin
		{rst_i, link_en, link_up, sync_n, realign, sref, spll, cpll} = 8'h80;
		{mf2, slot, m8, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
		{bad_count, checks_done, mdl_flags, mdl_mask} = '0;
		void'($urandom(32'h64e40987));
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		sw(CTL_IRQ_MASK_OFFSET, 8'h03, 0);
		mdl_mask = 3;
		foreach (ra[i]) begin
			dev(ra[i], 8'h00, 1, 2'b01);
			chk(v, 8'h00);
		end
		repeat (4) begin
			mdl_id = $urandom_range(255);
			dev(8'h06, mdl_id[7:0], 0, 2'b01);
			dev(8'h06, 8'h00, 1, 2'b01);
			chk(v, mdl_id[7:0]);
			chk(id_o, mdl_id[7:0]);
			@(posedge clk_sys_i);
			mf2 <= 1'b1;
			@(posedge clk_sys_i);
			mf2 <= 1'b0;
			#1 chk(mf2_o, mdl_id[7:0]);
			@(posedge clk_sys_i);
			#1 chk(mf2_o, 8'h00);
		end
		for (int s = 0; s < 5; s++) begin
			dev(8'h07, {6'h3F, s[1:0]}, 0, 2'b01);
			dev(8'h07, 8'h00, 1, 2'b01);
			chk(v, s[7:0] & 8'h03);
			@(posedge clk_sys_i);
			m8 <= (s < 4);
			slot <= 1'b1;
			@(posedge clk_sys_i);
			slot <= 1'b0;
			#1 chk(fe_o, (s < 4) ? ctab[s[1:0]] : 8'h00);
			chk(is_k, s < 4);
		end
		@(posedge clk_sys_i);
		link_en <= 1'b1;
		dev(8'h06, ~mdl_id[7:0], 0, 2'b10);
		dev(8'h06, 8'h00, 1, 2'b01);
		chk(v, mdl_id[7:0]);
		repeat (3) begin
			@(posedge clk_sys_i);
			{link_up, sync_n, spll, cpll} <= 4'($urandom);
			dev(8'h08, 8'h00, 1, 2'b01);
			chk(v[6], link_up);
			chk(v[5], sync_n);
			chk(v[2], spll);
			chk(v[0], cpll);
		end
		@(posedge clk_sys_i);
		{sref, realign} <= 2'b11;
		repeat (3) @(posedge clk_sys_i);
		{sref, realign} <= 2'b00;
		mdl_flags = 8'h18;
		dev(8'h08, 8'h00, 1, 2'b01);
		chk(v, stat());
		dev(8'h08, 8'h00, 0, 2'b01);
		dev(8'h08, 8'h00, 1, 2'b01);
		chk(v, stat());
		dev(8'h08, 8'hFF, 0, 2'b01);
		mdl_flags = 0;
		dev(8'h08, 8'h00, 1, 2'b01);
		chk(v, stat());
		@(posedge clk_sys_i);
		sref <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		sref <= 1'b0;
		dev(8'h08, 8'h00, 1, 2'b01);
		chk(v, stat());
		sw(CTL_IRQ_MASK_OFFSET, 8'h00, 0);
		mdl_mask = 0;
		dev(8'h06, 8'h00, 1, 2'b01);
		stop_test();
	end
endmodule
